// [hw/msbp_cm_writer.sv]
// connection memory write stage: registers one fill write per cycle
// assumes the memory accepts one write per clock
`default_nettype none
module msbp_cm_writer #(
  parameter int AW = 12
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  wr_en,
  input  wire logic [AW-1:0]         wr_addr,
  input  wire logic [2:0]            fill,
  output var  msbp_pkg::msbp_cm_wr_t cm_wr
);
  msbp_pkg::msbp_cm_wr_t next_cm_wr;

  // =====================================
  // word build
  always_comb begin
    next_cm_wr.we   = wr_en;
    next_cm_wr.addr = wr_addr;
    // high word and low bits 15..3 zero, fill in low bits 2..0
    next_cm_wr.data = {29'h0000000, fill};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cm_wr <= '0;
    end else begin
      cm_wr <= next_cm_wr;
    end
  end

  chk_fill_data: assert property (@(posedge clk) disable iff (reset)
    cm_wr.we |-> cm_wr.data[31:3] == 29'h0000000)
    else $error("fill word upper bits not zero");
  chk_fill_value: assert property (@(posedge clk) disable iff (reset)
    wr_en |=> cm_wr.data[2:0] == $past(fill))
    else $error("fill value not written");
endmodule
`default_nettype wire

// [hw/msbp_pkg.sv]
// package for the mode select and block programming register bank
// assumes a 16-bit register port and a frame pulse from switch timing
`default_nettype none
package msbp_pkg;
  // register offsets (word index on the register port)
  localparam logic [3:0] ADDR_MODE    = 4'h0;
  localparam logic [3:0] ADDR_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  // mode register field positions
  localparam int BIT_START        = 0;
  localparam int BIT_FILL_LO      = 1;
  localparam int BIT_TX_EN        = 4;
  localparam int BIT_RX_EN        = 5;
  localparam int BIT_LOW_BIDIR    = 6;
  localparam int BIT_HIGH_BIDIR   = 7;
  localparam int BIT_PULL_DOWN_EN = 8;
  // control register field position
  localparam int BIT_BP_EN    = 0;
  // reset values and mode register write mask
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h01ff;
  // frames needed to fill the connection memory
  localparam logic [1:0] FILL_FRAMES = 2'h2;
  // connection memory geometry
  localparam int CM_AW = 12;
  localparam int CM_DW = 32;

  typedef struct packed {
    logic              we;
    logic [CM_AW-1:0]  addr;
    logic [CM_DW-1:0]  data;
  } msbp_cm_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_DONE = 3'b100
  } msbp_state_t;
endpackage
`default_nettype wire

// [hw/msbp_top.sv]
// mode select register with connection memory block programming
// assumes frame_start pulses one cycle per frame, synchronous to clk
//
// Behaviour
// - transmitter master enable low disables every prbs transmitter.
// - block programming writes the fill value to low word bits 2..0 of every location.
// - block programming clears low word bits 15..3 and the whole high word.
// - programming runs only while both the enable bit and start bit are high.
// - a zero to one change of the start bit launches programming from idle.
// - the fill runs from launch to the second frame pulse once enabled.
// - the start bit clears itself when programming completes.
// - clearing start or enable while start is high aborts programming.
`default_nettype none
module msbp_top #(
  parameter int AW = 12
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  frame_start,
  input  wire logic [15:0]           low_streams_in,
  output logic      [15:0]           low_streams_sampled,
  output logic                       low_streams_bidir,
  output logic                       prbs_receiver_master_enable,
  output logic                       prbs_transmitter_master_enable,
  output logic                       bp_busy,
  output var  msbp_pkg::msbp_cm_wr_t cm_wr
);
  logic [15:0]           internal_mode_select;
  logic [15:0]           next_internal_mode_select;
  logic                  block_program_enable;
  logic                  next_block_program_enable;
  msbp_pkg::msbp_state_t state;
  msbp_pkg::msbp_state_t next_state;
  logic [1:0]            frames;
  logic [1:0]            next_frames;
  logic [AW-1:0]         addr;
  logic [AW-1:0]         next_addr;
  logic [15:0]           next_rdata;
  logic [15:0]           next_sampled;
  logic                  wr_mode;
  logic                  start_rise;
  logic                  abort;
  logic                  fill_en;
  logic                  complete;
  logic [1:0]            frames_seen;
  logic [1:0]            next_frames_seen;

  assign wr_mode = reg_wr && (reg_addr == msbp_pkg::ADDR_MODE);
  // rising edge of start from a register write
  assign start_rise = wr_mode && reg_wdata[msbp_pkg::BIT_START]
                      && !internal_mode_select[msbp_pkg::BIT_START];
  assign fill_en = (state == msbp_pkg::ST_FILL) && block_program_enable;
  assign complete = fill_en && frame_start && (frames == msbp_pkg::FILL_FRAMES - 2'h1);

  // =====================================
  // register file
  always_comb begin
    next_internal_mode_select = internal_mode_select;
    next_block_program_enable = block_program_enable;
    if (wr_mode) begin
      // start and fill taken in one write
      next_internal_mode_select = reg_wdata & msbp_pkg::MODE_WMASK;
    end
    if (reg_wr && reg_addr == msbp_pkg::ADDR_CTRL) begin
      next_block_program_enable = reg_wdata[msbp_pkg::BIT_BP_EN];
    end
    // completion clear wins over a software write of start
    if (complete) begin
      next_internal_mode_select[msbp_pkg::BIT_START] = 1'b0; // self clear
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      internal_mode_select <= msbp_pkg::MODE_RESET;
      block_program_enable <= msbp_pkg::CTRL_RESET[0];
    end else begin
      internal_mode_select <= next_internal_mode_select;
      block_program_enable <= next_block_program_enable;
    end
  end

  // =====================================
  // programming sequencer
  // abort when software drops start or enable mid run
  assign abort = (state == msbp_pkg::ST_FILL) &&
                 (!next_internal_mode_select[msbp_pkg::BIT_START] && !complete ||
                  !next_block_program_enable);

  always_comb begin
    next_state  = state;
    next_frames = frames;
    next_addr   = addr;
    case (state)
      msbp_pkg::ST_IDLE: begin
        next_frames = 2'h0;
        next_addr   = '0;
        if (start_rise) begin
          next_state = msbp_pkg::ST_FILL;
        end
      end
      msbp_pkg::ST_FILL: begin
        if (abort) begin
          next_state = msbp_pkg::ST_IDLE;
        end else if (complete) begin
          next_state = msbp_pkg::ST_DONE;
        end else if (fill_en) begin
          next_addr = addr + 1'b1;
          if (frame_start) begin
            next_frames = frames + 2'h1; // count whole frames
          end
        end
      end
      msbp_pkg::ST_DONE: begin
        next_state = msbp_pkg::ST_IDLE;
      end
      default: begin
        next_state = msbp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state  <= msbp_pkg::ST_IDLE;
      frames <= 2'h0;
      addr   <= '0;
    end else begin
      state  <= next_state;
      frames <= next_frames;
      addr   <= next_addr;
    end
  end

  msbp_cm_writer #(.AW(AW)) u_writer (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (fill_en && !abort),
    .wr_addr (addr),
    .fill    (internal_mode_select[msbp_pkg::BIT_FILL_LO +: 3]),
    .cm_wr   (cm_wr)
  );

  // =====================================
  // read port and mode outputs
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        msbp_pkg::ADDR_MODE:   next_rdata = internal_mode_select;
        msbp_pkg::ADDR_CTRL:   next_rdata = {15'h0000, block_program_enable};
        msbp_pkg::ADDR_STATUS: next_rdata = {14'h0000, frames};
        default:               next_rdata = 16'h0000;
      endcase
    end
    // bidir ties dedicated inputs low
    next_sampled = internal_mode_select[msbp_pkg::BIT_LOW_BIDIR] ? 16'h0000 : low_streams_in;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata                      <= 16'h0000;
      low_streams_sampled            <= 16'h0000;
      low_streams_bidir              <= 1'b0;
      prbs_receiver_master_enable    <= 1'b0;
      prbs_transmitter_master_enable <= 1'b0;
      bp_busy                        <= 1'b0;
    end else begin
      reg_rdata                      <= next_rdata;
      low_streams_sampled            <= next_sampled;
      low_streams_bidir              <= internal_mode_select[msbp_pkg::BIT_LOW_BIDIR];
      prbs_receiver_master_enable    <= internal_mode_select[msbp_pkg::BIT_RX_EN];
      prbs_transmitter_master_enable <= internal_mode_select[msbp_pkg::BIT_TX_EN];
      bp_busy                        <= next_state == msbp_pkg::ST_FILL;
    end
  end

  // =====================================
  // checks
  // frame pulses seen in fill, counted apart from the sequencer
  always_comb begin
    next_frames_seen = frames_seen;
    if (state != msbp_pkg::ST_FILL) begin
      next_frames_seen = 2'h0;
    end else if (frame_start && frames_seen != 2'h3) begin
      next_frames_seen = frames_seen + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frames_seen <= 2'h0;
    end else begin
      frames_seen <= next_frames_seen;
    end
  end

  chk_bidir_tie: assert property (@(posedge clk) disable iff (reset)
    internal_mode_select[msbp_pkg::BIT_LOW_BIDIR] |=> low_streams_sampled == 16'h0000)
    else $error("low streams not tied low");
  chk_rx_enable: assert property (@(posedge clk) disable iff (reset)
    !internal_mode_select[msbp_pkg::BIT_RX_EN] |=> !prbs_receiver_master_enable)
    else $error("receivers enabled while master off");
  chk_tx_enable: assert property (@(posedge clk) disable iff (reset)
    !internal_mode_select[msbp_pkg::BIT_TX_EN] |=> !prbs_transmitter_master_enable)
    else $error("transmitters enabled while master off");
  chk_needs_enable: assert property (@(posedge clk) disable iff (reset)
    u_writer.wr_en |-> block_program_enable && internal_mode_select[msbp_pkg::BIT_START])
    else $error("fill write without enable and start");
  chk_start_launch: assert property (@(posedge clk) disable iff (reset)
    start_rise && state == msbp_pkg::ST_IDLE |=> state == msbp_pkg::ST_FILL)
    else $error("start edge did not launch");
  chk_two_frames: assert property (@(posedge clk) disable iff (reset)
    state == msbp_pkg::ST_FILL && next_state == msbp_pkg::ST_DONE
    |-> frames_seen == 2'h1 && frame_start)
    else $error("fill did not span two frames");
  chk_self_clear: assert property (@(posedge clk) disable iff (reset)
    complete |=> !internal_mode_select[msbp_pkg::BIT_START] && state == msbp_pkg::ST_DONE)
    else $error("start not cleared on completion");
  chk_abort_stop: assert property (@(posedge clk) disable iff (reset)
    state == msbp_pkg::ST_FILL && !next_block_program_enable
    |=> state == msbp_pkg::ST_IDLE ##1 !cm_wr.we)
    else $error("abort did not stop programming");
  chk_abort_start: assert property (@(posedge clk) disable iff (reset)
    state == msbp_pkg::ST_FILL && !complete
    && !next_internal_mode_select[msbp_pkg::BIT_START]
    |=> state == msbp_pkg::ST_IDLE && !cm_wr.we)
    else $error("start clear did not abort programming");
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the mode select and block programming bank
// assumes the register port, frame pulse and fill writer of msbp_top
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic [3:0]            reg_addr = 4'h0;
  logic [15:0]           reg_wdata = 16'h0000;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [15:0]           reg_rdata;
  logic                  frame_start = 1'b0;
  logic [15:0]           low_streams_in = 16'h0000;
  logic [15:0]           low_streams_sampled;
  logic                  low_streams_bidir;
  logic                  rx_en;
  logic                  tx_en;
  logic                  bp_busy;
  msbp_pkg::msbp_cm_wr_t cm_wr;
  int                    fail_count = 0;
  int                    samples_checked = 0;
  int                    seed = 58357;
  int                    we_count = 0;
  int                    snap;
  logic [2:0]            fill = 3'h0;
  logic [15:0]           m;
  logic                  prev_we = 1'b0;
  logic [11:0]           prev_addr = 12'h000;

  msbp_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .low_streams_in(low_streams_in), .low_streams_sampled(low_streams_sampled),
    .low_streams_bidir(low_streams_bidir), .prbs_receiver_master_enable(rx_en),
    .prbs_transmitter_master_enable(tx_en), .bp_busy(bp_busy), .cm_wr(cm_wr));

  // ==========================================
  // clock and shared tasks
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic frame();
    @(posedge clk) frame_start <= 1'b1;
    @(posedge clk) frame_start <= 1'b0;
  endtask

  task automatic wait_busy(input logic v);
    int i;
    #1;
    for (i = 0; i < 40 && bp_busy !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (bp_busy !== v) begin
      fail_count++;
      $display("CHECK FAILED at %0t: busy wait ran out", $time);
      conclude();
    end
  endtask

  // ==========================================
  // fill write monitor: value and address stepping
  always @(posedge clk) begin
    if (cm_wr.we === 1'b1) begin
      we_count++;
      check(cm_wr.data, {29'h0, fill});
      if (prev_we) check(cm_wr.addr, 12'(prev_addr + 12'h001));
      else check(cm_wr.addr, 12'h000);
    end
    prev_we <= (cm_wr.we === 1'b1);
    prev_addr <= cm_wr.addr;
  end

  // ==========================================
  // main sequence
  initial begin
    int k;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd_check(msbp_pkg::ADDR_MODE, msbp_pkg::MODE_RESET);
    rd_check(msbp_pkg::ADDR_CTRL, msbp_pkg::CTRL_RESET);
    wr(4'hf, 16'hffff);
    rd_check(4'hf, 16'h0000);
    wr(msbp_pkg::ADDR_MODE, 16'hfe70);
    rd_check(msbp_pkg::ADDR_MODE, 16'h0070);
    // every combination of the three mode enables
    for (k = 0; k < 8; k++) begin
      wr(msbp_pkg::ADDR_MODE, 16'(k) << 4);
      low_streams_in <= 16'($random(seed));
      @(posedge clk);
      #1 check(low_streams_bidir, k[2]);
      check(rx_en, k[1]);
      check(tx_en, k[0]);
      check(low_streams_sampled, k[2] ? 16'h0000 : low_streams_in);
    end
    // full fill over two frames
    fill = 3'($random(seed));
    m = 16'h0030 | (16'(fill) << 1) | 16'h0001;
    wr(msbp_pkg::ADDR_CTRL, 16'h0001);
    wr(msbp_pkg::ADDR_MODE, m);
    wait_busy(1'b1);
    frame();
    // frame long enough to reach every location
    repeat (4100) @(posedge clk);
    #1 check(bp_busy, 1'b1);
    rd_check(msbp_pkg::ADDR_STATUS, 16'h0001);
    frame();
    wait_busy(1'b0);
    check(we_count >= 4096, 1'b1);
    rd_check(msbp_pkg::ADDR_MODE, m & 16'hfffe);
    // start with enable low writes nothing
    wr(msbp_pkg::ADDR_CTRL, 16'h0000);
    snap = we_count;
    wr(msbp_pkg::ADDR_MODE, m);
    repeat (10) @(posedge clk);
    check(we_count === snap, 1'b1);
    wr(msbp_pkg::ADDR_MODE, m & 16'hfffe);
    wr(msbp_pkg::ADDR_CTRL, 16'h0001);
    repeat (10) @(posedge clk);
    check(we_count === snap, 1'b1);
    // abort by clearing start, then by clearing enable
    for (k = 0; k < 2; k++) begin
      wr(msbp_pkg::ADDR_MODE, m);
      wait_busy(1'b1);
      if (k == 0) wr(msbp_pkg::ADDR_MODE, m & 16'hfffe);
      else wr(msbp_pkg::ADDR_CTRL, 16'h0000);
      wait_busy(1'b0);
      snap = we_count;
      repeat (6) @(posedge clk);
      check(we_count === snap, 1'b1);
      wr(msbp_pkg::ADDR_MODE, m & 16'hfffe);
      wr(msbp_pkg::ADDR_CTRL, 16'h0001);
    end
    conclude();
  end
endmodule
`default_nettype wire
